// file: core/uef_pkg.sv
// Shared constants for the endpoint access block
package uef_pkg;
   // Register addresses on the special register port
   localparam logic [7:0] ADDR_LINE = 8'h1A;
   localparam logic [7:0] ADDR_EVT = 8'h1B;
   localparam logic [7:0] ADDR_CMD = 8'h46;
   localparam logic [7:0] ADDR_EP0 = 8'h48;
   localparam logic [7:0] ADDR_EP1 = 8'h49;
   localparam logic [7:0] ADDR_EP2 = 8'h4A;
   // Command register fields
   localparam int CMD_REQ = 0;
   localparam int CMD_TX = 1;
   localparam int CMD_CLR = 2;
   localparam int CMD_SEL_LO = 3;
   localparam int CMD_SEL_HI = 4;
   localparam int CMD_SETUP = 5;
   localparam int CMD_READY = 6;
   localparam int CMD_ZERO_LENGTH_FLAG = 7;
   localparam logic [1:0] SEL_RESERVED = 2'h3;
   localparam logic [7:0] CMD_RST = 8'h00;
   // Line control fields
   localparam int LINE_BUS_SUSPENDED = 0;
   localparam int LINE_WAKE = 1;
   localparam int LINE_BRST = 2;
   localparam int LINE_RESUME = 3;
   localparam int LINE_DIN = 4;
   localparam int LINE_CIN = 5;
   localparam int LINE_DOUT = 6;
   localparam int LINE_COUT = 7;
   localparam logic LINE_OUT_RST = 1'b1;
   // Event flag fields
   localparam int EVT_PS2 = 4;
   localparam int EVT_USB = 5;
   localparam int EVT_MODE = 7;
   localparam logic SEL_RST = 1'b0;
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int SETTLE_NS = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int RESUME_MS = 20;
   localparam int RESUME_CYC = RESUME_MS * CLK_MHZ * 1000;
   localparam int TMR_W = 9;
   // Command sequencer states, Gray along the path
   typedef enum logic [1:0] {
      UEF_IDLE = 2'h0,
      UEF_WAIT = 2'h1,
      UEF_ACTIVE = 2'h3,
      UEF_SETTLE = 2'h2
   } uef_state_t;
endpackage

// file: core/uef_timer_if.sv
`timescale 1ns/100ps
// Handshake between the sequencer and the interval timer
interface uef_timer_if;
   logic ce;
   logic start;
   logic slow_sel;
   logic busy;
   logic done;
   modport owner (output ce, output start, output slow_sel,
                  input busy, input done);
   modport timer (input ce, input start, input slow_sel,
                  output busy, output done);
endinterface

// file: core/uef_interval_timer.sv
`timescale 1ns/100ps
// Microsecond interval timer for settling and request waits
module uef_interval_timer
   import uef_pkg::*;
#(
   parameter int CYC = SETTLE_CYC
)(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Control
   uef_timer_if.timer tmr
);
   logic [TMR_W-1:0] cnt; // Cycles remaining
   logic [TMR_W-1:0] next_cnt;
   logic busy; // Interval running
   logic next_busy;
   logic done; // Interval end pulse
   logic next_done;
   logic [TMR_W-1:0] limit; // Span for the chosen oscillator

   // Span halves when the slower oscillator is selected
   assign limit = tmr.slow_sel ? TMR_W'(CYC / 2) : TMR_W'(CYC);

   // Next count
   always_comb
   begin
      next_cnt = cnt;
      next_busy = busy;
      next_done = 1'b0;
      if (tmr.start)
      begin
         // Restart always wins
         next_cnt = limit - TMR_W'(1);
         next_busy = 1'b1;
      end
      else if (busy)
      begin
         if (cnt == '0)
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
         else
            next_cnt = cnt - TMR_W'(1);
      end
   end

   // Registers, frozen by clock enable
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (tmr.ce)
      begin
         cnt <= next_cnt;
         busy <= next_busy;
         done <= next_done;
      end
   end

   assign tmr.busy = busy;
   assign tmr.done = done;

   // Fast interval stays busy for a long stretch
   a_timer_span: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (tmr.ce && tmr.start && !tmr.slow_sel) |=> busy[*8])
      else $error("interval timer ended too early");
endmodule

// file: core/uef_endpoint_access.sv
`timescale 1ns/100ps
// Functional notes
// - three byte data ports at 48H-4AH
// - next byte only after settling interval
// - readability probe reports 41H or 01H
// - writability probe reports 4BH or 0BH
// - zero length packet reports 81H
// - suspend indication, interrupt on each change
// - bus reset indication raises interrupt
// - resume indication shown, wakes MCU
// - raw line input levels readable
// - line drive bits default high
// - endpoint request flags raise gated interrupt
// - keyboard port select resets to zero
// - usb function select resets to zero
// - usb mode flag cleared by reset
// - command register field layout
// - bus reset clears command register
module uef_endpoint_access
   import uef_pkg::*;
#(
   parameter int RESUME_CYCLES = RESUME_CYC,
   parameter int RES_W = 22
)(
   // Clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Special register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // System context
   input wire logic clk_6mhz_sel_i,
   input wire logic usb_irq_en_i,
   input wire logic stack_full_i,
   // Serial engine status
   input wire logic bus_reset_i,
   input wire logic bus_suspend_i,
   input wire logic [2:0] ep_access_i,
   input wire logic [2:0] ep_ready_i,
   input wire logic [2:0] ep_zero_len_i,
   input wire logic setup_rx_i,
   input wire logic [23:0] ep_rdata_i,
   // Serial engine commands
   output logic [2:0] ep_pop_o,
   output logic [2:0] ep_push_o,
   output logic [7:0] ep_wdata_o,
   output logic [2:0] ep_clear_o,
   output logic [2:0] ep_release_o,
   output logic ep_dir_tx_o,
   output logic remote_wakeup_o,
   output logic resume_wake_o,
   output logic usb_irq_o,
   output logic keyboard_port_select_o,
   output logic usb_function_select_o,
   // Line pins, D- data and D+ clock
   input wire logic dm_i,
   output logic dm_o,
   output logic dm_oe_o,
   input wire logic dp_i,
   output logic dp_o,
   output logic dp_oe_o
);
   localparam int WAKE_CYC = SETTLE_CYC;

   uef_timer_if tmr ();

   // Command sequencer state
   uef_state_t state, next_state;
   logic [7:0] cmd, next_cmd; // Command and status
   logic tmr_start; // Launch interval
   // Line control state
   logic bus_suspended_q, next_bus_suspended_q; // Last suspend level
   logic wake_bit, next_wake_bit; // Wakeup command bit
   logic [TMR_W-1:0] wake_cnt, next_wake_cnt; // Hold counter
   logic [TMR_W-1:0] wake_lim; // Hold span for the chosen oscillator
   logic next_remote_wakeup;
   logic bus_reset_seen, next_bus_reset_seen;
   logic resume, next_resume; // Resume indication
   logic [RES_W-1:0] res_cnt, next_res_cnt; // Resume visibility
   // Event flags and selects
   logic [2:0] ep_flag, next_ep_flag; // Endpoint request flags
   logic ps2_sel, next_ps2_sel;
   logic usb_sel, next_usb_sel;
   logic usb_mode, next_usb_mode;
   logic data_line_out, next_data_line_out;
   logic clock_line_out, next_clock_line_out;
   // Registered outputs
   logic [7:0] next_rdata;
   logic [2:0] next_pop, next_push, next_clear, next_release;
   logic [7:0] next_wdata;
   logic next_dir_tx, next_irq;
   // Decode
   logic wr_cmd, wr_line, wr_evt, dp_hit;
   logic [1:0] dp_ep; // Endpoint of the data port hit
   logic [1:0] sel; // Selected endpoint
   logic sel_ok; // Selection not reserved
   logic flag_irq; // Gated endpoint event

   // Register port decode
   assign wr_cmd = reg_wr_i && (reg_addr_i == ADDR_CMD);
   assign wr_line = reg_wr_i && (reg_addr_i == ADDR_LINE);
   assign wr_evt = reg_wr_i && (reg_addr_i == ADDR_EVT);
   assign dp_hit = (reg_addr_i == ADDR_EP0) || (reg_addr_i == ADDR_EP1) ||
                   (reg_addr_i == ADDR_EP2);
   assign dp_ep = 2'(reg_addr_i - ADDR_EP0);
   assign sel = cmd[CMD_SEL_HI:CMD_SEL_LO];
   assign sel_ok = (sel != SEL_RESERVED);
   assign flag_irq = (|ep_access_i) && usb_irq_en_i && !stack_full_i;

   // Timer hookup
   assign tmr.ce = ce_i;
   assign tmr.start = tmr_start;
   assign tmr.slow_sel = clk_6mhz_sel_i;
   // Wakeup hold halves with the slower oscillator as well
   assign wake_lim = clk_6mhz_sel_i ? TMR_W'(WAKE_CYC / 2) :
                     TMR_W'(WAKE_CYC);

   uef_interval_timer #(
      .CYC(SETTLE_CYC)
   ) u_timer (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .tmr(tmr.timer)
   );

   // Command register and request sequencer
   always_comb
   begin
      next_state = state;
      next_cmd = cmd;
      tmr_start = 1'b0;
      next_pop = 3'h0;
      next_push = 3'h0;
      next_clear = 3'h0;
      next_release = 3'h0;
      next_wdata = ep_wdata_o;
      next_dir_tx = ep_dir_tx_o;
      if (wr_cmd)
      begin
         // Ready stays hardware owned
         next_cmd = reg_wdata_i;
         next_cmd[CMD_READY] = cmd[CMD_READY] &&
            (reg_wdata_i[CMD_SEL_HI:CMD_SEL_LO] != SEL_RESERVED);
         // Clear bit rising flushes the chosen buffer
         if (reg_wdata_i[CMD_CLR] && !cmd[CMD_CLR] && sel_ok)
            next_clear[sel] = 1'b1;
         if (reg_wdata_i[CMD_REQ] && !cmd[CMD_REQ])
         begin
            // New request waits out the interval
            next_state = UEF_WAIT;
            next_cmd[CMD_READY] = 1'b0;
            tmr_start = 1'b1;
         end
         else if (!reg_wdata_i[CMD_REQ] && cmd[CMD_REQ])
         begin
            // Request dropped ends the transfer
            next_state = UEF_IDLE;
            next_cmd[CMD_READY] = 1'b0;
            if (sel_ok)
               next_release[sel] = 1'b1;
            next_dir_tx = cmd[CMD_TX];
         end
      end
      case (state)
         UEF_IDLE:
         begin
            // Nothing in flight
         end
         UEF_WAIT:
         begin
            if (tmr.done && !wr_cmd)
            begin
               // Status becomes visible after the wait
               next_state = UEF_ACTIVE;
               next_cmd[CMD_READY] = sel_ok && ep_ready_i[sel] &&
                                     !ep_zero_len_i[sel];
               if (sel_ok && ep_zero_len_i[sel])
                  next_cmd[CMD_ZERO_LENGTH_FLAG] = 1'b1;
               if (setup_rx_i && (sel == 2'h0))
                  next_cmd[CMD_SETUP] = 1'b1;
            end
         end
         UEF_ACTIVE:
         begin
            if (dp_hit && (reg_rd_i || reg_wr_i) && !wr_cmd)
            begin
               // Data access, next byte after settling
               next_state = UEF_SETTLE;
               next_cmd[CMD_READY] = 1'b0;
               tmr_start = 1'b1;
               if (reg_rd_i)
                  next_pop[dp_ep] = 1'b1;
               else
               begin
                  next_push[dp_ep] = 1'b1;
                  next_wdata = reg_wdata_i;
               end
            end
         end
         UEF_SETTLE:
         begin
            if (tmr.done && !wr_cmd)
            begin
               next_state = UEF_ACTIVE;
               next_cmd[CMD_READY] = sel_ok && ep_ready_i[sel];
            end
         end
         default:
            next_state = UEF_IDLE;
      endcase
      if (bus_reset_i)
      begin
         // Bus reset wipes the command register
         next_cmd = CMD_RST;
         next_state = UEF_IDLE;
      end
   end

   // Line control, wakeup and resume
   always_comb
   begin
      next_bus_suspended_q = bus_suspend_i;
      next_wake_bit = wake_bit;
      next_wake_cnt = wake_cnt;
      next_bus_reset_seen = bus_reset_seen;
      next_resume = resume;
      next_res_cnt = res_cnt;
      next_data_line_out = data_line_out;
      next_clock_line_out = clock_line_out;
      if (wr_line)
      begin
         next_wake_bit = reg_wdata_i[LINE_WAKE];
         next_data_line_out = reg_wdata_i[LINE_DOUT];
         next_clock_line_out = reg_wdata_i[LINE_COUT];
         if (!reg_wdata_i[LINE_BRST])
            next_bus_reset_seen = 1'b0;
      end
      // Wakeup accepted only after the full hold
      if (!wake_bit)
         next_wake_cnt = '0;
      else if (wake_cnt < wake_lim)
         next_wake_cnt = wake_cnt + TMR_W'(1);
      next_remote_wakeup = wake_bit && (wake_cnt >= wake_lim);
      // Set wins over the firmware clear
      if (bus_reset_i)
         next_bus_reset_seen = 1'b1;
      if (bus_suspended_q && !bus_suspend_i)
      begin
         // Leaving suspend starts the visible window
         next_resume = 1'b1;
         next_res_cnt = RES_W'(RESUME_CYCLES - 1);
      end
      else if (resume)
      begin
         if (bus_suspend_i || (res_cnt == '0))
            next_resume = 1'b0;
         else
            next_res_cnt = res_cnt - RES_W'(1);
      end
   end

   // Endpoint request flags, set wins over clear
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_flag
         always_comb
         begin
            next_ep_flag[i] = ep_flag[i];
            if (wr_evt)
               next_ep_flag[i] = reg_wdata_i[i];
            if (ep_access_i[i])
               next_ep_flag[i] = 1'b1;
         end
      end
   endgenerate

   // Selects, mode flag, interrupt and read data
   always_comb
   begin
      next_ps2_sel = wr_evt ? reg_wdata_i[EVT_PS2] : ps2_sel;
      next_usb_sel = wr_evt ? reg_wdata_i[EVT_USB] : usb_sel;
      next_usb_mode = wr_evt ? reg_wdata_i[EVT_MODE] : usb_mode;
      // One interrupt event per change or request
      next_irq = (bus_suspend_i != bus_suspended_q) || bus_reset_i ||
                 (bus_suspended_q && !bus_suspend_i) || flag_irq;
      next_rdata = reg_rdata_o;
      if (reg_rd_i)
      begin
         next_rdata = 8'h00;
         if (reg_addr_i == ADDR_CMD)
            next_rdata = cmd;
         else if (reg_addr_i == ADDR_LINE)
         begin
            // Write-only bits read as zero
            next_rdata[LINE_BUS_SUSPENDED] = bus_suspended_q;
            next_rdata[LINE_BRST] = bus_reset_seen;
            next_rdata[LINE_RESUME] = resume;
            next_rdata[LINE_DIN] = dm_i;
            next_rdata[LINE_CIN] = dp_i;
         end
         else if (reg_addr_i == ADDR_EVT)
         begin
            next_rdata[2:0] = ep_flag;
            next_rdata[EVT_PS2] = ps2_sel;
            next_rdata[EVT_USB] = usb_sel;
            next_rdata[EVT_MODE] = usb_mode;
         end
         else if (dp_hit)
            next_rdata = ep_rdata_i[8*dp_ep +: 8];
      end
   end

   // All state registers, frozen while enable is low
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state <= UEF_IDLE;
         cmd <= CMD_RST;
         bus_suspended_q <= 1'b0;
         wake_bit <= 1'b0;
         wake_cnt <= '0;
         remote_wakeup_o <= 1'b0;
         bus_reset_seen <= 1'b0;
         resume <= 1'b0;
         res_cnt <= '0;
         resume_wake_o <= 1'b0;
         ep_flag <= 3'h0;
         ps2_sel <= SEL_RST;
         usb_sel <= SEL_RST;
         usb_mode <= SEL_RST;
         data_line_out <= LINE_OUT_RST;
         clock_line_out <= LINE_OUT_RST;
         reg_rdata_o <= 8'h00;
         ep_pop_o <= 3'h0;
         ep_push_o <= 3'h0;
         ep_wdata_o <= 8'h00;
         ep_clear_o <= 3'h0;
         ep_release_o <= 3'h0;
         ep_dir_tx_o <= 1'b0;
         usb_irq_o <= 1'b0;
         keyboard_port_select_o <= SEL_RST;
         usb_function_select_o <= SEL_RST;
         dm_oe_o <= 1'b0;
         dp_oe_o <= 1'b0;
      end
      else if (ce_i)
      begin
         state <= next_state;
         cmd <= next_cmd;
         bus_suspended_q <= next_bus_suspended_q;
         wake_bit <= next_wake_bit;
         wake_cnt <= next_wake_cnt;
         remote_wakeup_o <= next_remote_wakeup;
         bus_reset_seen <= next_bus_reset_seen;
         resume <= next_resume;
         res_cnt <= next_res_cnt;
         resume_wake_o <= next_resume;
         ep_flag <= next_ep_flag;
         ps2_sel <= next_ps2_sel;
         usb_sel <= next_usb_sel;
         usb_mode <= next_usb_mode;
         data_line_out <= next_data_line_out;
         clock_line_out <= next_clock_line_out;
         reg_rdata_o <= next_rdata;
         ep_pop_o <= next_pop;
         ep_push_o <= next_push;
         ep_wdata_o <= next_wdata;
         ep_clear_o <= next_clear;
         ep_release_o <= next_release;
         ep_dir_tx_o <= next_dir_tx;
         usb_irq_o <= next_irq;
         keyboard_port_select_o <= next_ps2_sel;
         usb_function_select_o <= next_usb_sel;
         dm_oe_o <= next_ps2_sel;
         dp_oe_o <= next_ps2_sel;
      end
   end

   // Pin levels come straight from the drive bits
   assign dm_o = data_line_out;
   assign dp_o = clock_line_out;

   // Bus reset leaves command register clear
   a_cmd_bus_reset: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_reset_i) |=> (cmd == 8'h00))
      else $error("command register not cleared by bus reset");

   // Ready only rises after an interval end
   a_ready_after_wait: assert property (@(posedge mclk_i)
      disable iff (!rst_b_i)
      $rose(cmd[CMD_READY]) |-> $past(tmr.done))
      else $error("ready rose without settling interval");

   // Zero length packet reports length flag, not ready
   a_zlp_status: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && state == UEF_WAIT && tmr.done && !wr_cmd && !bus_reset_i
       && sel_ok && ep_zero_len_i[sel])
      |=> (cmd[CMD_ZERO_LENGTH_FLAG] && !cmd[CMD_READY]))
      else $error("zero length status wrong");

   // Reserved selection never reports ready
   a_reserved_sel: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (cmd[CMD_SEL_HI:CMD_SEL_LO] == 2'h3 && $stable(cmd))
      |-> !cmd[CMD_READY])
      else $error("reserved endpoint reported ready");

   // Suspend change raises interrupt
   a_bus_suspended_irq: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_suspend_i != bus_suspended_q) |=> usb_irq_o)
      else $error("suspend change gave no interrupt");

   // Bus reset shows indication and interrupt
   a_reset_seen: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_reset_i) |=> (bus_reset_seen && usb_irq_o))
      else $error("bus reset indication missing");

   // Leaving suspend shows resume and wakes
   a_resume_set: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_suspended_q && !bus_suspend_i) |=> (resume && resume_wake_o))
      else $error("resume indication missing");

   // Endpoint access sets flag and gated interrupt
   a_flag_irq: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && ep_access_i[0] && usb_irq_en_i && !stack_full_i)
      |=> (ep_flag[0] && usb_irq_o))
      else $error("endpoint flag or interrupt missing");

   // Line inputs read back raw
   a_line_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && reg_rd_i && reg_addr_i == ADDR_LINE)
      |=> (reg_rdata_o[LINE_DIN] == $past(dm_i) &&
           reg_rdata_o[LINE_CIN] == $past(dp_i)))
      else $error("line input levels misread");

   // Data port read pops the addressed buffer
   a_port_pop: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && reg_rd_i && reg_addr_i == ADDR_EP0 && state == UEF_ACTIVE
       && !wr_cmd) |=> (ep_pop_o == 3'h1))
      else $error("data port read did not pop");

   // Drivers released while keyboard port is off
   a_pin_release: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && !wr_evt && !ps2_sel) |=> (!dm_oe_o && !dp_oe_o))
      else $error("line driven outside keyboard mode");
endmodule

// file: bench/uef_engine_model.sv
`timescale 1ns/100ps
// Serial engine stand-in: byte source per buffer, byte sink for endpoint 1 only
module uef_engine_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Buffer commands from the block
   input wire logic [2:0] pop_i,
   input wire logic [2:0] push_i,
   input wire logic [7:0] wdata_i,
   input wire logic [2:0] clear_i,
   // Current bytes and last byte taken
   output logic [23:0] rdata_o,
   output logic [7:0] last_o
);
   // Each pop or flush moves a buffer on to a new byte
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rdata_o <= 24'h3C5AA5;
         last_o <= 8'h00;
      end
      else
      begin
         for (int n = 0; n < 3; n++)
            if (pop_i[n] || clear_i[n])
               rdata_o[8*n +: 8] <= rdata_o[8*n +: 8] + 8'h01;
         // Endpoint 1 is the transmit buffer
         if (push_i[1])
            last_o <= wdata_i;
      end
   end
endmodule

// file: bench/uef_endpoint_access_tb_top.sv
`timescale 1ns/100ps
// Register traffic against the endpoint access block
module uef_endpoint_access_tb_top import uef_pkg::*;;
   // Driven inputs
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic irq_en = 1'b0;
   logic stk = 1'b0;
   logic brst = 1'b0;
   logic bus_suspended = 1'b0;
   logic [2:0] acc = 3'h0;
   logic [2:0] rdy = 3'h7;
   logic [2:0] zl = 3'h0;
   logic dm = 1'b1;
   logic dp = 1'b0;
   logic slow = 1'b0;
   logic stp = 1'b0;
   // Observed outputs
   logic [7:0] rdata, wbyte, last, got;
   logic [23:0] bytes;
   logic [2:0] pop, push, clr, rel;
   logic rwk, rsm, irq, kps, ufs, dmo, dmoe, dpo, dpoe, dir;
   // Output event tallies
   int irqs = 0, pops = 0, pushes = 0, clrs = 0, rels = 0, b;
   int mismatches = 0, compares = 0;

   always #4 clk = ~clk;

   uef_endpoint_access #(.RESUME_CYCLES(50)) dut (
      .mclk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .clk_6mhz_sel_i(slow), .usb_irq_en_i(irq_en),
      .stack_full_i(stk), .bus_reset_i(brst),
      .bus_suspend_i(bus_suspended), .ep_access_i(acc),
      .ep_ready_i(rdy), .ep_zero_len_i(zl), .setup_rx_i(stp),
      .ep_rdata_i(bytes), .ep_pop_o(pop), .ep_push_o(push),
      .ep_wdata_o(wbyte), .ep_clear_o(clr),
      .ep_release_o(rel), .ep_dir_tx_o(dir),
      .remote_wakeup_o(rwk), .resume_wake_o(rsm),
      .usb_irq_o(irq), .keyboard_port_select_o(kps),
      .usb_function_select_o(ufs), .dm_i(dm), .dm_o(dmo),
      .dm_oe_o(dmoe), .dp_i(dp), .dp_o(dpo), .dp_oe_o(dpoe)
   );

   uef_engine_model eng (
      .mclk_i(clk), .rst_b_i(rst_b), .pop_i(pop),
      .push_i(push), .wdata_i(wbyte), .clear_i(clr),
      .rdata_o(bytes), .last_o(last)
   );

   // Count pulses seen on the command outputs
   always @(posedge clk)
   begin
      irqs += (irq === 1'b1);
      pops += (pop[0] === 1'b1);
      pushes += (push[1] === 1'b1);
      clrs += (clr[1] === 1'b1);
      rels += (|rel === 1'b1);
   end

   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(string n, logic e, logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask
   task automatic rc(string n, logic [7:0] a, logic [7:0] e);
      rreg(a);
      chk8(n, e, got);
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic done(string n);
      $display("test %s finished", n);
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Watchdog, well past the expected run
   initial
   begin
      #400000;
      mismatches++;
      conclude;
   end

   initial
   begin
      cyc(6);
      rst_b <= 1'b1;
      chk1("dm_o", 1'b1, dmo);
      chk1("dp_o", 1'b1, dpo);
      rc("line", 8'h1A, 8'h10);
      rc("events", 8'h1B, 8'h00);
      rc("cmd", 8'h46, 8'h00);
      rc("unmapped", 8'h1C, 8'h00);
      dm <= 1'b0;
      dp <= 1'b1;
      rc("line", 8'h1A, 8'h20);
      done("reset");
      // Endpoint 0 read with settling between bytes
      wreg(8'h46, 8'h00);
      wreg(8'h46, 8'h01);
      cyc(260);
      rc("cmd", 8'h46, 8'h41);
      rc("ep0", 8'h48, 8'hA5);
      rc("cmd", 8'h46, 8'h01);
      chk8("pops", 8'h01, 8'(pops));
      cyc(260);
      rc("ep0", 8'h48, 8'hA6);
      cyc(260);
      b = rels;
      wreg(8'h46, 8'h03);
      wreg(8'h46, 8'h02);
      cyc(3);
      chk8("release", 8'h01, 8'(rels - b));
      chk1("dir", 1'b1, dir);
      done("read");
      // Endpoint 1 write
      wreg(8'h46, 8'h0A);
      wreg(8'h46, 8'h0B);
      cyc(260);
      rc("cmd", 8'h46, 8'h4B);
      wreg(8'h49, 8'h5A);
      cyc(2);
      chk8("pushes", 8'h01, 8'(pushes));
      chk8("byte", 8'h5A, last);
      rc("cmd", 8'h46, 8'h0B);
      cyc(260);
      wreg(8'h49, 8'hC3);
      cyc(2);
      chk8("byte", 8'hC3, last);
      b = rels;
      wreg(8'h46, 8'h09);
      wreg(8'h46, 8'h08);
      cyc(3);
      chk8("release", 8'h01, 8'(rels - b));
      chk1("dir", 1'b0, dir);
      done("write");
      // Probes with buffers not ready
      rdy <= 3'h0;
      wreg(8'h46, 8'h0A);
      wreg(8'h46, 8'h0B);
      cyc(260);
      rc("cmd", 8'h46, 8'h0B);
      wreg(8'h46, 8'h0A);
      wreg(8'h46, 8'h00);
      wreg(8'h46, 8'h01);
      cyc(260);
      rc("cmd", 8'h46, 8'h01);
      wreg(8'h46, 8'h00);
      // Slow oscillator halves the wait, setup packet flagged
      slow <= 1'b1;
      stp <= 1'b1;
      wreg(8'h46, 8'h01);
      cyc(130);
      rc("cmd", 8'h46, 8'h21);
      slow <= 1'b0;
      stp <= 1'b0;
      wreg(8'h46, 8'h00);
      done("probe");
      // Zero length packet in, then write probe with flush
      zl <= 3'h1;
      wreg(8'h46, 8'h01);
      cyc(260);
      rc("cmd", 8'h46, 8'h81);
      rreg(8'h48);
      zl <= 3'h0;
      wreg(8'h46, 8'h03);
      rc("cmd", 8'h46, 8'h03);
      wreg(8'h46, 8'h02);
      wreg(8'h46, 8'h0A);
      wreg(8'h46, 8'h0B);
      cyc(260);
      rc("cmd", 8'h46, 8'h0B);
      b = clrs;
      wreg(8'h46, 8'h0F);
      cyc(2);
      chk8("clear", 8'h01, 8'(clrs - b));
      b = rels;
      wreg(8'h46, 8'h0D);
      wreg(8'h46, 8'h08);
      cyc(3);
      chk8("release", 8'h01, 8'(rels - b));
      done("zero");
      // Bus reset mid request
      wreg(8'h46, 8'h01);
      b = irqs;
      brst <= 1'b1;
      cyc(1);
      brst <= 1'b0;
      cyc(3);
      chk8("irq", 8'h01, 8'(irqs - b));
      rc("cmd", 8'h46, 8'h00);
      rc("line", 8'h1A, 8'h24);
      wreg(8'h1A, 8'hC0);
      rc("line", 8'h1A, 8'h20);
      done("busreset");
      // Suspend, then resume window
      b = irqs;
      bus_suspended <= 1'b1;
      cyc(4);
      rc("line", 8'h1A, 8'h21);
      chk8("irq", 8'h01, 8'(irqs - b));
      b = irqs;
      bus_suspended <= 1'b0;
      cyc(4);
      rc("line", 8'h1A, 8'h28);
      chk1("wake", 1'b1, rsm);
      chk1("irq", 1'b1, irqs > b);
      cyc(60);
      rc("line", 8'h1A, 8'h20);
      done("suspend");
      // Endpoint flags, interrupt gating
      irq_en <= 1'b1;
      b = irqs;
      acc <= 3'h5;
      cyc(1);
      acc <= 3'h0;
      stk <= 1'b1;
      cyc(3);
      rc("events", 8'h1B, 8'h05);
      acc <= 3'h2;
      cyc(1);
      acc <= 3'h0;
      cyc(3);
      rc("events", 8'h1B, 8'h07);
      chk8("irq", 8'h01, 8'(irqs - b));
      wreg(8'h1B, 8'h00);
      rc("events", 8'h1B, 8'h00);
      done("flags");
      // Selects, drive levels, wakeup hold
      wreg(8'h1B, 8'hB0);
      rc("events", 8'h1B, 8'hB0);
      chk1("kps", 1'b1, kps);
      chk1("ufs", 1'b1, ufs);
      chk1("dm_oe", 1'b1, dmoe);
      chk1("dp_oe", 1'b1, dpoe);
      wreg(8'h1A, 8'h02);
      cyc(2);
      chk1("dm_o", 1'b0, dmo);
      chk1("dp_o", 1'b0, dpo);
      cyc(260);
      chk1("rwk", 1'b1, rwk);
      wreg(8'h1A, 8'h00);
      cyc(2);
      chk1("rwk", 1'b0, rwk);
      done("select");
      conclude;
   end
endmodule
